// file: hdl/pch_cfg_regs.sv
`timescale 1ns/1ns
`include "pch_regs.svh"
// Overview of operation
// [R01] status/command 32 bits; writable only by config writes, read-only elsewhere
// [R02] parity error flag bit 31 sets on any detected error; write one clears
// [R03] bit 30 sets whenever system error is driven; write one clears
// [R04] bit 29 sets on own master abort; write one clears
// [R05] bit 28 sets on received target abort as initiator; write one clears
// [R06] bit 27 sets on signalled target abort; write one clears
// [R07] bits 26:25 read fixed medium select timing 01
// [R08] bit 24 sets on perr as master with parity response on
// [R09] unimplemented command/status bits and 23:9 read zero
// [R10] system error driven only while bit 8 set; reset clears
// [R11] parity checked only while bit 6 set
// [R12] bus ownership requested only while bit 2 set; reset clears
// [R13] memory and io claims gated by bits 1 and 0; reset clears
// [R14] power-up 0x02000000; command reset keeps 8,6,1,0, forces bit 2
// [R15] class code bits 31:8 fixed 068000
// [R16] class/revision read-only; low byte revision code
// [R17] latency timer 15:8, upper five bits writable, reset clears
// [R18] self-test, header layout, cache-line bytes read zero
// [R19] io base claims 256 bytes; 31:8 writable, bit 0 reads one
// [R20] host memory base 64MB window, bits 31:26 writable
// [R21] register window base 8KB, bits 31:13 writable
// [R22] bases undefined at power-up (reset loads zero here), kept across command reset
// [R23] claim only inside a window with matching space enable
module pch_cfg_regs import pch_pkg::*; #(
  parameter logic [7:0] REVISION = 8'h5a  // arbitrary revision code
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_cmd_reset,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic        i_lb_rd,
  input  wire logic [7:0]  i_lb_addr,
  input  wire logic        i_par_err,
  input  wire logic        i_perr_as_master,
  input  wire logic        i_serr_req,
  input  wire logic        i_master_abort,
  input  wire logic        i_target_abort_rx,
  input  wire logic        i_target_abort_tx,
  input  wire logic        i_bus_req,
  input  wire logic        i_acc_valid,
  input  wire logic        i_acc_io,
  input  wire logic [31:0] i_acc_addr,
  output logic [31:0]      o_rdata,
  output logic             o_serr_n_oe,
  output logic             o_bus_req,
  output logic             o_par_check,
  output logic             o_claim,
  output logic             o_claim_io,
  output logic             o_claim_hm,
  output logic             o_claim_mm,
  output logic [7:0]       o_lat_timer
);

  pch_state_s st;
  pch_state_s next_st;
  logic [31:0] statcmd;

  // assemble a register image; unmapped offsets read zero
  function automatic logic [31:0] reg_image(input pch_state_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == `PCH_OFS_STATCMD) begin
      v = {s.flags.detected_parity_error, s.flags.signalled_system_error, s.flags.signalled_master_abort, s.flags.received_target_abort, s.flags.signalled_target_abort,
           `PCH_DEVSEL_MEDIUM, s.flags.data_parity_detected, 15'h0, s.serr_en, 1'b0, s.par_en,
           3'h0, s.bm_en, s.mem_en, s.io_en};  // R07 R09
    end else if (a == `PCH_OFS_CLASSREV) begin
      v = {`PCH_CLASS_CODE, REVISION};  // R15 R16
    end else if (a == `PCH_OFS_LATMISC) begin
      v = {16'h0, s.lat, 3'h0, 8'h0};  // R17 R18
    end else if (a == `PCH_OFS_IOBASE) begin
      v = {s.io_base, 8'h01};  // R19
    end else if (a == `PCH_OFS_HMBASE) begin
      v = {s.hm_base, 26'h0};  // R20
    end else if (a == `PCH_OFS_MMBASE) begin
      v = {s.mm_base, 13'h0};  // R21
    end
    return v;
  endfunction

  // merge written bytes with current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  assign statcmd = reg_image(st, `PCH_OFS_STATCMD);

  // next state: hardware sets win over write-one-to-clear
  always_comb begin
    logic [31:0] w;
    logic [31:0] clr;
    logic        wr_sc;
    w = merge(reg_image(st, i_cfg_addr), i_cfg_wdata, i_cfg_be);
    clr = 32'h0;
    next_st = st;
    wr_sc = i_cfg_wr && (i_cfg_addr == `PCH_OFS_STATCMD);  // R01
    for (int i = 0; i < 4; i++) begin
      if (wr_sc && i_cfg_be[i]) clr[i*8 +: 8] = i_cfg_wdata[i*8 +: 8];
    end
    if (wr_sc) begin
      next_st.serr_en = w[`PCH_BIT_SERR_EN];
      next_st.par_en  = w[`PCH_BIT_PAR_EN];
      next_st.bm_en   = w[`PCH_BIT_BM_EN];
      next_st.mem_en  = w[`PCH_BIT_MEM_EN];
      next_st.io_en   = w[`PCH_BIT_IO_EN];
    end
    next_st.flags.detected_parity_error = (st.flags.detected_parity_error & ~clr[`PCH_BIT_DPE_FLAG]) | i_par_err;  // R02
    next_st.flags.signalled_system_error = (st.flags.signalled_system_error & ~clr[`PCH_BIT_SSE_FLAG]) | o_serr_n_oe == 1'b0;  // R03
    next_st.flags.signalled_master_abort = (st.flags.signalled_master_abort & ~clr[`PCH_BIT_SMA_FLAG]) | i_master_abort;  // R04
    next_st.flags.received_target_abort = (st.flags.received_target_abort & ~clr[`PCH_BIT_RTA_FLAG]) | i_target_abort_rx;  // R05
    next_st.flags.signalled_target_abort = (st.flags.signalled_target_abort & ~clr[`PCH_BIT_STA_FLAG]) | i_target_abort_tx;  // R06
    next_st.flags.data_parity_detected = (st.flags.data_parity_detected & ~clr[`PCH_BIT_DPD_FLAG])
                      | (i_perr_as_master & st.par_en);  // R08
    // base and timer writes, low bits are not stored at all
    if (i_cfg_wr && i_cfg_addr == `PCH_OFS_LATMISC) next_st.lat = w[15:11];  // R17
    if (i_cfg_wr && i_cfg_addr == `PCH_OFS_IOBASE)  next_st.io_base = w[31:`PCH_IO_BASE_LSB];  // R19
    if (i_cfg_wr && i_cfg_addr == `PCH_OFS_HMBASE)  next_st.hm_base = w[31:`PCH_HM_BASE_LSB];  // R20
    if (i_cfg_wr && i_cfg_addr == `PCH_OFS_MMBASE)  next_st.mm_base = w[31:`PCH_MM_BASE_LSB];  // R21
    // read data: config reads win over local bus reads; local bus never writes
    if (i_cfg_rd)     next_st.rdata = reg_image(st, i_cfg_addr);
    else if (i_lb_rd) next_st.rdata = reg_image(st, i_lb_addr);  // R01
    // command reset: keep enables 8,6,1,0, force bit 2, clear flags, keep timer and bases
    if (i_cmd_reset) begin
      next_st.flags   = '0;  // R14
      next_st.bm_en   = 1'b1;
      next_st.lat     = st.lat;
      next_st.io_base = st.io_base;  // R22
      next_st.hm_base = st.hm_base;
      next_st.mm_base = st.mm_base;
      next_st.serr_en = st.serr_en;
      next_st.par_en  = st.par_en;
      next_st.mem_en  = st.mem_en;
      next_st.io_en   = st.io_en;
    end
  end

  // bases get a zero power-up value since undefined is not synthesizable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;  // R14 R22
    end else begin
      st <= next_st;
    end
  end

  // outputs towards the bus engine; serr and bus request gated by their enables
  assign o_rdata     = st.rdata;
  assign o_serr_n_oe = ~(i_serr_req & st.serr_en);  // R10
  assign o_bus_req   = i_bus_req & st.bm_en;  // R12
  assign o_par_check = st.par_en;  // R11
  assign o_lat_timer = {st.lat, 3'h0};
  // window decode; io window is 256 bytes, others by their base width
  assign o_claim_io  = i_acc_valid & i_acc_io & st.io_en
                     & (i_acc_addr[31:`PCH_IO_BASE_LSB] == st.io_base);  // R13 R23
  assign o_claim_hm  = i_acc_valid & ~i_acc_io & st.mem_en
                     & (i_acc_addr[31:`PCH_HM_BASE_LSB] == st.hm_base);  // R13 R23
  assign o_claim_mm  = i_acc_valid & ~i_acc_io & st.mem_en
                     & (i_acc_addr[31:`PCH_MM_BASE_LSB] == st.mm_base);  // R23
  assign o_claim     = o_claim_io | o_claim_hm | o_claim_mm;

  property p_dpe_set;
    @(posedge i_clk) disable iff (!i_nrst) i_par_err && !i_cmd_reset |=> statcmd[31];
  endproperty
  a_dpe_set: assert property (p_dpe_set) else $error("parity flag not set");  // R02

  property p_sse_set;
    @(posedge i_clk) disable iff (!i_nrst) !o_serr_n_oe && !i_cmd_reset |=> statcmd[30];
  endproperty
  a_sse_set: assert property (p_sse_set) else $error("serr flag not set");  // R03

  property p_sma_set;
    @(posedge i_clk) disable iff (!i_nrst) i_master_abort && !i_cmd_reset |=> statcmd[29];
  endproperty
  a_sma_set: assert property (p_sma_set) else $error("master abort flag not set");  // R04

  property p_dpd_gate;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(statcmd[24]) |-> $past(i_perr_as_master) && $past(statcmd[6]);
  endproperty
  a_dpd_gate: assert property (p_dpd_gate) else $error("data parity flag set without cause");  // R08

  property p_devsel;
    @(posedge i_clk) disable iff (!i_nrst) statcmd[26:25] == 2'h1 && statcmd[23:9] == 15'h0;
  endproperty
  a_devsel: assert property (p_devsel) else $error("fixed status bits wrong");  // R07

  property p_serr_gate;
    @(posedge i_clk) disable iff (!i_nrst) !o_serr_n_oe |-> statcmd[8];
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("serr driven while disabled");  // R10

  property p_bm_gate;
    @(posedge i_clk) disable iff (!i_nrst) o_bus_req |-> statcmd[2];
  endproperty
  a_bm_gate: assert property (p_bm_gate) else $error("bus request while master disabled");  // R12

  property p_claim_gate;
    @(posedge i_clk) disable iff (!i_nrst)
      (o_claim_io |-> statcmd[0]) and (o_claim_hm |-> statcmd[1]);
  endproperty
  a_claim_gate: assert property (p_claim_gate) else $error("claim while space disabled");  // R13

  property p_cmd_reset;
    @(posedge i_clk) disable iff (!i_nrst) i_cmd_reset |=> statcmd[2] && statcmd[31:27] == 5'h0;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset) else $error("command reset value wrong");  // R14

  property p_rta_set;
    @(posedge i_clk) disable iff (!i_nrst)
      i_target_abort_rx && !i_cmd_reset |=> statcmd[28];
  endproperty
  a_rta_set: assert property (p_rta_set) else $error("received abort flag not set");  // R05

  property p_sta_set;
    @(posedge i_clk) disable iff (!i_nrst)
      i_target_abort_tx && !i_cmd_reset |=> statcmd[27];
  endproperty
  a_sta_set: assert property (p_sta_set) else $error("signalled abort flag not set");  // R06

  property p_dpe_clear;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_wr && i_cfg_addr == `PCH_OFS_STATCMD && i_cfg_be[3] && i_cfg_wdata[31] && !i_par_err |=> !statcmd[31];
  endproperty
  a_dpe_clear: assert property (p_dpe_clear) else $error("parity flag not cleared");  // R02

  property p_sse_clear;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_wr && i_cfg_addr == `PCH_OFS_STATCMD && i_cfg_be[3] && i_cfg_wdata[30] && o_serr_n_oe |=> !statcmd[30];
  endproperty
  a_sse_clear: assert property (p_sse_clear) else $error("serr flag not cleared");  // R03

  property p_sma_cause;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(statcmd[29]) |-> $past(i_master_abort);
  endproperty
  a_sma_cause: assert property (p_sma_cause) else $error("master abort flag set without cause");  // R04

  property p_dpd_set;
    @(posedge i_clk) disable iff (!i_nrst)
      i_perr_as_master && statcmd[6] && !i_cmd_reset |=> statcmd[24];
  endproperty
  a_dpd_set: assert property (p_dpd_set) else $error("data parity flag not set");  // R08

  property p_hardwired;
    @(posedge i_clk) disable iff (!i_nrst)
      statcmd[7] == 1'b0 && statcmd[5:3] == 3'h0;
  endproperty
  a_hardwired: assert property (p_hardwired) else $error("unimplemented command bits not zero");  // R09

  property p_serr_follow;
    @(posedge i_clk) disable iff (!i_nrst)
      i_serr_req && statcmd[8] |-> !o_serr_n_oe;
  endproperty
  a_serr_follow: assert property (p_serr_follow) else $error("serr not driven while enabled");  // R10

  property p_bm_follow;
    @(posedge i_clk) disable iff (!i_nrst)
      i_bus_req && statcmd[2] |-> o_bus_req;
  endproperty
  a_bm_follow: assert property (p_bm_follow) else $error("bus request dropped while enabled");  // R12

  property p_par_check;
    @(posedge i_clk) disable iff (!i_nrst)
      o_par_check == statcmd[6];
  endproperty
  a_par_check: assert property (p_par_check) else $error("parity check not following enable");  // R11

  property p_cmd_keep;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_reset |=> statcmd[8] == $past(statcmd[8]) && statcmd[6] == $past(statcmd[6])
                     && statcmd[1:0] == $past(statcmd[1:0]);
  endproperty
  a_cmd_keep: assert property (p_cmd_keep) else $error("command reset lost an enable");  // R14

  property p_class_cfg;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_rd && i_cfg_addr == `PCH_OFS_CLASSREV |=> o_rdata == {`PCH_CLASS_CODE, REVISION};
  endproperty
  a_class_cfg: assert property (p_class_cfg) else $error("class code read wrong");  // R15

  property p_class_lb;
    @(posedge i_clk) disable iff (!i_nrst)
      i_lb_rd && !i_cfg_rd && i_lb_addr == `PCH_OFS_CLASSREV |=> o_rdata == {`PCH_CLASS_CODE, REVISION};
  endproperty
  a_class_lb: assert property (p_class_lb) else $error("class code local read wrong");  // R16

  property p_lat_low;
    @(posedge i_clk) disable iff (!i_nrst)
      o_lat_timer[2:0] == 3'h0;
  endproperty
  a_lat_low: assert property (p_lat_low) else $error("latency low bits not zero");  // R17

  property p_lat_write;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_wr && i_cfg_addr == `PCH_OFS_LATMISC && i_cfg_be[1] && !i_cmd_reset
      |=> o_lat_timer[7:3] == $past(i_cfg_wdata[15:11]);
  endproperty
  a_lat_write: assert property (p_lat_write) else $error("latency timer write lost");  // R17

  property p_misc_zero;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_rd && i_cfg_addr == `PCH_OFS_LATMISC |=> o_rdata[31:16] == 16'h0 && o_rdata[7:0] == 8'h0;
  endproperty
  a_misc_zero: assert property (p_misc_zero) else $error("misc fixed bytes not zero");  // R18

  property p_io_low;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_rd && i_cfg_addr == `PCH_OFS_IOBASE |=> o_rdata[7:0] == 8'h01;
  endproperty
  a_io_low: assert property (p_io_low) else $error("io base low byte wrong");  // R19

  property p_hm_low;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_rd && i_cfg_addr == `PCH_OFS_HMBASE |=> o_rdata[25:0] == 26'h0;
  endproperty
  a_hm_low: assert property (p_hm_low) else $error("host window low bits not zero");  // R20

  property p_mm_low;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cfg_rd && i_cfg_addr == `PCH_OFS_MMBASE |=> o_rdata[12:0] == 13'h0;
  endproperty
  a_mm_low: assert property (p_mm_low) else $error("register window low bits not zero");  // R21

  property p_base_keep;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cmd_reset |=> st.io_base == $past(st.io_base) && st.hm_base == $past(st.hm_base)
                     && st.mm_base == $past(st.mm_base);
  endproperty
  a_base_keep: assert property (p_base_keep) else $error("base lost over command reset");  // R22

  property p_claim_mm_gate;
    @(posedge i_clk) disable iff (!i_nrst)
      o_claim_mm |-> statcmd[1] && !i_acc_io;
  endproperty
  a_claim_mm_gate: assert property (p_claim_mm_gate) else $error("register window claim while disabled");  // R23

  property p_claim_valid;
    @(posedge i_clk) disable iff (!i_nrst)
      o_claim |-> i_acc_valid;
  endproperty
  a_claim_valid: assert property (p_claim_valid) else $error("claim without an access");  // R23

endmodule

// file: common/pch_regs.svh
`ifndef PCH_REGS_SVH
`define PCH_REGS_SVH
// register offsets (config space dword addresses)
`define PCH_OFS_STATCMD   8'h04
`define PCH_OFS_CLASSREV  8'h08
`define PCH_OFS_LATMISC   8'h0c
`define PCH_OFS_IOBASE    8'h10
`define PCH_OFS_HMBASE    8'h14
`define PCH_OFS_MMBASE    8'h18
// status/command field positions
`define PCH_BIT_DPE_FLAG  31
`define PCH_BIT_SSE_FLAG  30
`define PCH_BIT_SMA_FLAG  29
`define PCH_BIT_RTA_FLAG  28
`define PCH_BIT_STA_FLAG  27
`define PCH_BIT_DPD_FLAG  24
`define PCH_BIT_SERR_EN   8
`define PCH_BIT_PAR_EN    6
`define PCH_BIT_BM_EN     2
`define PCH_BIT_MEM_EN    1
`define PCH_BIT_IO_EN     0
`define PCH_DEVSEL_MEDIUM 2'h1
// reset values
`define PCH_STATCMD_RST   32'h02000000
`define PCH_CLASS_CODE    24'h068000
// lowest writable bit positions of the window bases and the latency timer
`define PCH_IO_BASE_LSB   8
`define PCH_HM_BASE_LSB   26
`define PCH_MM_BASE_LSB   13
`define PCH_LAT_LSB       3
`endif

// file: common/pch_pkg.sv
package pch_pkg;
  // status flags as a group
  typedef struct packed {
    logic detected_parity_error;
    logic signalled_system_error;
    logic signalled_master_abort;
    logic received_target_abort;
    logic signalled_target_abort;
    logic data_parity_detected;
  } pch_flags_s;
  // all block state
  typedef struct packed {
    pch_flags_s  flags;
    logic        serr_en;
    logic        par_en;
    logic        bm_en;
    logic        mem_en;
    logic        io_en;
    logic [4:0]  lat;
    logic [23:0] io_base;
    logic [5:0]  hm_base;
    logic [18:0] mm_base;
    logic [31:0] rdata;
  } pch_state_s;
endpackage

// file: dv/pch_host_model.sv
`timescale 1ns/1ns
// host side of config space: one access per call, launched on a falling edge
module pch_host_model (
  input  wire logic        i_clk,
  output logic             o_cfg_wr,
  output logic             o_cfg_rd,
  output logic             o_lb_rd,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_be
);
  initial begin
    {o_cfg_wr, o_cfg_rd, o_lb_rd} = 3'h0;
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_be = 4'h0;
  end
  // kind 0 config write, 1 config read, 2 local read; the local side never writes
  task automatic acc(input int kind, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_be = b;
    {o_cfg_wr, o_cfg_rd, o_lb_rd} = 3'h1 << (2 - kind);
    @(negedge i_clk);
    {o_cfg_wr, o_cfg_rd, o_lb_rd} = 3'h0;
    // stale bus values must not look valid
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

// file: dv/pch_cfg_regs_tb.sv
`timescale 1ns/1ns
module pch_cfg_regs_tb;
  localparam logic [7:0] REV = 8'h5a;
  logic        i_clk, i_nrst, cmd_rst, bus_req, acc_v, acc_io, seen;
  logic        cw, cr, lr, serr_oe, breq, pchk, clm, clm_io, clm_hm, clm_mm;
  logic [5:0]  ev;  // par, perr as master, mabort, ta rx, ta tx, serr
  logic [7:0]  addr, lat;
  logic [3:0]  be;
  logic [31:0] wd, acc_addr, rdata, io_b, hm_b, mm_b;
  logic [31:0] q[$];
  int          failures, checks, cyc;

  pch_host_model host (.i_clk(i_clk), .o_cfg_wr(cw), .o_cfg_rd(cr), .o_lb_rd(lr), .o_addr(addr),
    .o_wdata(wd), .o_be(be));
  pch_cfg_regs #(.REVISION(REV)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_reset(cmd_rst),
    .i_cfg_wr(cw), .i_cfg_rd(cr), .i_cfg_addr(addr), .i_cfg_wdata(wd), .i_cfg_be(be), .i_lb_rd(lr),
    .i_lb_addr(addr), .i_par_err(ev[5]), .i_perr_as_master(ev[4]), .i_serr_req(ev[0]),
    .i_master_abort(ev[3]), .i_target_abort_rx(ev[2]), .i_target_abort_tx(ev[1]), .i_bus_req(bus_req),
    .i_acc_valid(acc_v), .i_acc_io(acc_io), .i_acc_addr(acc_addr), .o_rdata(rdata), .o_serr_n_oe(serr_oe),
    .o_bus_req(breq), .o_par_check(pchk), .o_claim(clm), .o_claim_io(clm_io), .o_claim_hm(clm_hm),
    .o_claim_mm(clm_mm), .o_lat_timer(lat));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
    host.acc(0, a, d, b);
  endtask
  // the expectation is noted before the read is launched
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input int lb = 0);
    q.push_back(e);
    host.acc(lb ? 2 : 1, a, 32'h0, 4'h0);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(negedge i_clk);
    ev = m;
    @(negedge i_clk);
    ev = 6'h0;
  endtask
  // serr drive and bus request follow their enables combinationally
  task automatic gate(input logic s_on, input logic b_on);
    @(negedge i_clk);
    ev = 6'h01;
    bus_req = 1'b1;
    #1;
    chk("serr_oe", {31'h0, serr_oe}, {31'h0, ~s_on});
    chk("bus_req", {31'h0, breq}, {31'h0, b_on});
    ev = 6'h0;
    bus_req = 1'b0;
  endtask
  task automatic claim(input logic io, input logic [31:0] a, input logic [2:0] e);
    @(negedge i_clk);
    acc_v = 1'b1;
    acc_io = io;
    acc_addr = a;
    #1;
    chk("claims", {29'h0, clm_io, clm_hm, clm_mm}, {29'h0, e});
    chk("claim", {31'h0, clm}, {31'h0, |e});
    acc_v = 1'b0;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // read words are registered: compare one falling edge after the taking edge
  always @(posedge i_clk) seen <= cr | lr;
  always @(negedge i_clk) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      final_report();
    end
    if (seen) chk("rdata", rdata, q.size() ? q.pop_front() : 32'hx);
  end

  initial begin
    {i_nrst, cmd_rst, bus_req, acc_v, acc_io, seen} = 6'h0;
    ev = 6'h0;
    acc_addr = 32'h0;
    void'($urandom(40984));
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    rd(8'h04, 32'h02000000);
    rd(8'h08, {24'h068000, REV});
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h1);
    gate(1'b0, 1'b0);
    $display("reset values done");
    io_b = $urandom;
    hm_b = $urandom;
    mm_b = $urandom;
    mm_b[31] = ~hm_b[31];  // keep the two memory windows apart
    wr(8'h04, 32'hffffffff);
    wr(8'h08, 32'hffffffff);
    wr(8'h0c, 32'hffffffff);
    wr(8'h20, 32'hffffffff);
    wr(8'h10, io_b);
    wr(8'h14, hm_b);
    wr(8'h18, mm_b);
    rd(8'h04, 32'h02000147);
    rd(8'h04, 32'h02000147, 1);
    rd(8'h08, {24'h068000, REV}, 1);
    rd(8'h0c, 32'h0000f800);
    rd(8'h10, {io_b[31:8], 8'h01});
    rd(8'h14, {hm_b[31:26], 26'h0});
    rd(8'h18, {mm_b[31:13], 13'h0});
    rd(8'h20, 32'h0);
    chk("lat", {24'h0, lat}, 32'h0000f8);
    $display("write masks done");
    claim(1'b1, {io_b[31:8], 8'($urandom)}, 3'b100);
    claim(1'b1, {~io_b[31], io_b[30:8], 8'h0}, 3'b000);
    claim(1'b0, {hm_b[31:26], 26'($urandom)}, 3'b010);
    claim(1'b0, {mm_b[31:13], 13'($urandom)}, 3'b001);
    $display("window claims done");
    gate(1'b1, 1'b1);
    chk("par_check", {31'h0, pchk}, 32'h1);
    pulse(6'h3f);
    rd(8'h04, 32'hfb000147);
    wr(8'h04, 32'h80000000, 4'h8);
    rd(8'h04, 32'h7b000147);
    wr(8'h04, 32'h79000147);
    rd(8'h04, 32'h02000147);
    $display("status flags done");
    wr(8'h04, 32'h00000101);
    claim(1'b0, {hm_b[31:26], 26'h0}, 3'b000);
    claim(1'b0, {mm_b[31:13], 13'h0}, 3'b000);
    pulse(6'h38);
    rd(8'h04, 32'ha2000101);
    gate(1'b1, 1'b0);
    @(negedge i_clk);
    cmd_rst = 1'b1;
    @(negedge i_clk);
    cmd_rst = 1'b0;
    rd(8'h04, 32'h02000105);
    rd(8'h10, {io_b[31:8], 8'h01});
    rd(8'h0c, 32'h0000f800);
    $display("command reset done");
    @(negedge i_clk);
    i_nrst = 1'b0;
    @(negedge i_clk);
    i_nrst = 1'b1;
    rd(8'h04, 32'h02000000);
    rd(8'h0c, 32'h0);
    repeat (3) @(negedge i_clk);
    $display("second reset done");
    final_report();
  end
endmodule
